// ### fst_pkg.sv
// Constants for the FIFO status and transmit-length register block
package fst_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          CNT_W           = 12;
    localparam int          FIFO_DEPTH      = 12;
    localparam int          LVL_W           = 4;
    // Register offsets
    localparam logic [7:0]  OFS_FIFO_STATUS = 8'h1c;
    localparam logic [7:0]  OFS_TX_LEN_UP   = 8'h1d;
    localparam logic [7:0]  OFS_TX_LEN_LO   = 8'h1e;
    // Reset values
    localparam logic [7:0]  RST_TX_LEN      = 8'h00;
    localparam logic [7:0]  RST_RDATA       = 8'h00;
    // Status register field positions
    localparam int          ST_RSVD_BIT     = 7;
    localparam int          ST_HIGH_BIT     = 6;
    localparam int          ST_LOW_BIT      = 5;
    localparam int          ST_OVF_BIT      = 4;
    // Lower length register field positions
    localparam int          LO_CNT_MSB      = 7;
    localparam int          LO_CNT_LSB      = 4;
    localparam int          LO_BITS_MSB     = 3;
    localparam int          LO_BITS_LSB     = 1;
    localparam int          LO_PART_BIT     = 0;
    // Level thresholds in bytes
    localparam logic [3:0]  HIGH_LEVEL      = 4'h9;
    localparam logic [3:0]  LOW_LEVEL       = 4'h3;
endpackage

// ### fst_fifo_status.sv
// FIFO status and transmit-length registers of the reader's byte FIFO
//
// Summary of operation
// - Status bit 7 is reserved and always reads zero.
// - While receiving, status bit 6 sets once nine bytes sit in the FIFO.
// - While transmitting, status bit 5 sets when only three bytes remain.
// - Status bit 4 flags overflow when a byte is pushed into a full FIFO with no pop in the same cycle.
// - Status bits 3..0 give the unread byte count minus one, and zero when the FIFO is empty.
// - Upper length register bits 7..4 hold byte count bits 11..8.
// - Upper length register bits 3..0 hold byte count bits 7..4.
// - Both length registers clear at reset and while chip enable is low.
// - Both length registers clear at the end-of-frame of a transmission.
// - Lower length register holds low count, partial-byte flag and its bit count.
// - Lower length register bits 7..4 hold byte count bits 3..0.
`timescale 1ns/1ps
`default_nettype none
module fst_fifo_status
    import fst_pkg::*;
#(
    parameter int DEPTH = fst_pkg::FIFO_DEPTH
)
(
    input  wire logic                        I_CLK,
    input  wire logic                        I_SRST,
    input  wire logic                        I_CHIP_EN,
    input  wire logic [fst_pkg::ADDR_W-1:0]  I_ADDR,
    input  wire logic                        I_WR,
    input  wire logic [fst_pkg::DATA_W-1:0]  I_WDATA,
    input  wire logic                        I_RD,
    input  wire logic                        I_FIFO_PUSH,
    input  wire logic                        I_FIFO_POP,
    input  wire logic                        I_FIFO_CLEAR,
    input  wire logic                        I_RX_ACTIVE,
    input  wire logic                        I_TX_ACTIVE,
    input  wire logic                        I_TX_EOF,
    output logic [fst_pkg::DATA_W-1:0]       O_RDATA,
    output logic [fst_pkg::DATA_W-1:0]       O_STATUS,
    output logic [fst_pkg::CNT_W-1:0]        O_TX_COUNT,
    output logic                             O_TX_PARTIAL,
    output logic [2:0]                       O_TX_PARTIAL_BITS,
    output logic                             O_FIFO_FULL
);
    import fst_pkg::*;

    // Occupancy constants at the counter width
    localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(DEPTH);
    localparam logic [LVL_W-1:0] ONE_L   = LVL_W'(1);
    localparam logic [LVL_W-1:0] EMPTY_L = '0;

    // Chip enable synchroniser
    logic                 en_s1_r;
    logic                 en_s1_nxt;
    logic                 en_s2_r;
    logic                 en_s2_nxt;

    // FIFO occupancy
    logic [LVL_W-1:0]     level_r;
    logic [LVL_W-1:0]     level_nxt;
    logic                 push_ok;
    logic                 pop_ok;

    // Sticky overflow
    logic                 ovf_r;
    logic                 ovf_nxt;

    // Transmit length registers
    logic [DATA_W-1:0]    len_up_r;
    logic [DATA_W-1:0]    len_up_nxt;
    logic [DATA_W-1:0]    len_lo_r;
    logic [DATA_W-1:0]    len_lo_nxt;
    logic                 wr_up_hit;
    logic                 wr_lo_hit;

    // Status image and full flag
    logic [DATA_W-1:0]    status_r;
    logic [DATA_W-1:0]    status_nxt;
    logic                 full_r;
    logic                 full_nxt;
    logic                 high_lvl;
    logic                 low_lvl;

    // Read data
    logic [DATA_W-1:0]    rdata_r;
    logic [DATA_W-1:0]    rdata_nxt;

    // Unread count shown as N minus one, saturating at zero when empty
    function automatic logic [3:0] count_code(input logic [LVL_W-1:0] n);
        count_code = (n == EMPTY_L) ? 4'h0 : 4'(n - ONE_L);
    endfunction

    // Write strobe aimed at one register offset
    function automatic logic wr_hit(
        input logic              wr,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        wr_hit = wr && (addr == ofs);
    endfunction

    // Synchroniser next values: the pin shifts into the first flop
    always_comb
    begin
        en_s1_nxt = I_CHIP_EN;
        en_s2_nxt = en_s1_r;
    end

    // Synchroniser flops; reset leaves the block disabled
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
        end
        else
        begin
            en_s1_r <= en_s1_nxt;
            en_s2_r <= en_s2_nxt;
        end
    end

    // A push counts when there is room or a pop frees a slot in the same cycle
    assign push_ok = I_FIFO_PUSH && ((level_r < DEPTH_L) || pop_ok);
    assign pop_ok  = I_FIFO_POP && (level_r != EMPTY_L);

    // Occupancy: clear and disable empty the FIFO
    always_comb
    begin
        level_nxt = level_r;
        if (push_ok && !pop_ok)
        begin
            level_nxt = level_r + ONE_L;
        end
        else if (pop_ok && !push_ok)
        begin
            level_nxt = level_r - ONE_L;
        end
        if (I_FIFO_CLEAR)
        begin
            level_nxt = EMPTY_L;
        end
        if (!en_s2_r)
        begin
            level_nxt = EMPTY_L;
        end
    end

    // Occupancy flop
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            level_r <= EMPTY_L;
        end
        else
        begin
            level_r <= level_nxt;
        end
    end

    // Overflow: a refused push sets it and wins over a clear; disable beats all
    always_comb
    begin
        ovf_nxt = ovf_r;
        if (I_FIFO_CLEAR)
        begin
            ovf_nxt = 1'b0;
        end
        if (I_FIFO_PUSH && !push_ok)
        begin
            ovf_nxt = 1'b1;
        end
        if (!en_s2_r)
        begin
            ovf_nxt = 1'b0;
        end
    end

    // Overflow flop
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            ovf_r <= 1'b0;
        end
        else
        begin
            ovf_r <= ovf_nxt;
        end
    end

    // Length write decode
    assign wr_up_hit = wr_hit(I_WR, I_ADDR, OFS_TX_LEN_UP);
    assign wr_lo_hit = wr_hit(I_WR, I_ADDR, OFS_TX_LEN_LO);

    // Length registers: end of frame beats a write, disable beats all
    always_comb
    begin
        len_up_nxt = len_up_r;
        len_lo_nxt = len_lo_r;
        if (wr_up_hit)
        begin
            len_up_nxt = I_WDATA;
        end
        if (wr_lo_hit)
        begin
            len_lo_nxt = I_WDATA;
        end
        if (I_TX_EOF)
        begin
            len_up_nxt = RST_TX_LEN;
            len_lo_nxt = RST_TX_LEN;
        end
        if (!en_s2_r)
        begin
            len_up_nxt = RST_TX_LEN;
            len_lo_nxt = RST_TX_LEN;
        end
    end

    // Length flops
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            len_up_r <= RST_TX_LEN;
            len_lo_r <= RST_TX_LEN;
        end
        else
        begin
            len_up_r <= len_up_nxt;
            len_lo_r <= len_lo_nxt;
        end
    end

    // Level flags judged on the occupancy after this edge
    assign high_lvl = I_RX_ACTIVE && (level_nxt >= HIGH_LEVEL);
    assign low_lvl  = I_TX_ACTIVE && (level_nxt <= LOW_LEVEL);

    // Status image rebuilt every clock
    always_comb
    begin
        status_nxt                 = '0;
        status_nxt[ST_RSVD_BIT]    = 1'b0;
        status_nxt[ST_HIGH_BIT]    = high_lvl;
        status_nxt[ST_LOW_BIT]     = low_lvl;
        status_nxt[ST_OVF_BIT]     = ovf_nxt;
        status_nxt[ST_OVF_BIT-1:0] = count_code(level_nxt);
        full_nxt                   = (level_nxt == DEPTH_L);
    end

    // Status and full flops
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            status_r <= '0;
            full_r   <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            full_r   <= full_nxt;
        end
    end

    // Read path: no side effect, answered one clock after the strobe
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (I_RD)
        begin
            unique case (I_ADDR)
                OFS_FIFO_STATUS: rdata_nxt = status_r;
                OFS_TX_LEN_UP:   rdata_nxt = len_up_r;
                OFS_TX_LEN_LO:   rdata_nxt = len_lo_r;
                default:         rdata_nxt = RST_RDATA;
            endcase
        end
    end

    // Read data flop holds its value between reads
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            rdata_r <= RST_RDATA;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from flops
    assign O_RDATA           = rdata_r;
    assign O_STATUS          = status_r;
    assign O_TX_COUNT        = {len_up_r, len_lo_r[LO_CNT_MSB:LO_CNT_LSB]};
    assign O_TX_PARTIAL      = len_lo_r[LO_PART_BIT];
    assign O_TX_PARTIAL_BITS = len_lo_r[LO_BITS_MSB:LO_BITS_LSB];
    assign O_FIFO_FULL       = full_r;
endmodule
`default_nettype wire

// ### fst_fifo_status_asserts.sv
// Checker for the FIFO status and length register block
`timescale 1ns/1ps
`default_nettype none
module fst_fifo_status_asserts
    import fst_pkg::*;
#(
    parameter int DEPTH = fst_pkg::FIFO_DEPTH
)
(
    input wire logic        I_CLK,
    input wire logic        I_SRST,
    input wire logic        I_CHIP_EN,
    input wire logic [7:0]  I_ADDR,
    input wire logic        I_WR,
    input wire logic [7:0]  I_WDATA,
    input wire logic        I_RD,
    input wire logic        I_FIFO_PUSH,
    input wire logic        I_FIFO_CLEAR,
    input wire logic        I_TX_EOF,
    input wire logic [7:0]  O_RDATA,
    input wire logic [7:0]  O_STATUS,
    input wire logic [11:0] O_TX_COUNT,
    input wire logic        O_TX_PARTIAL,
    input wire logic [2:0]  O_TX_PARTIAL_BITS,
    input wire logic        O_FIFO_FULL
);
    logic [2:0] en_q;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    // Chip enable seen high for three edges, conservative
    always_ff @(posedge I_CLK) en_q <= I_SRST ? 3'h0 : {en_q[1:0], I_CHIP_EN};
    AST_RSVD: assert property (!O_STATUS[7])
        else $error("status b7 set");
    AST_HIGH: assert property (O_STATUS[6] |-> O_STATUS[3:0] >= 4'h8)
        else $error("high flag early");
    AST_LOW: assert property (O_STATUS[5] |-> O_STATUS[3:0] <= 4'h2)
        else $error("low flag late");
    AST_FULL: assert property (O_FIFO_FULL |-> O_STATUS[3:0] == 4'(DEPTH - 1))
        else $error("full count wrong");
    AST_EOF: assert property (I_TX_EOF |=> O_TX_COUNT == 12'h000 && !O_TX_PARTIAL)
        else $error("eof not cleared");
    AST_UP: assert property (I_WR && I_ADDR == 8'h1d && &en_q && !I_TX_EOF
        |=> O_TX_COUNT[11:4] == $past(I_WDATA)) else $error("upper write lost");
    AST_LO: assert property (I_WR && I_ADDR == 8'h1e && &en_q && !I_TX_EOF
        |=> {O_TX_COUNT[3:0], O_TX_PARTIAL_BITS, O_TX_PARTIAL} == $past(I_WDATA))
        else $error("lower write lost");
    AST_OFF: assert property (en_q == 3'h0 |=> O_TX_COUNT == 12'h000)
        else $error("length kept while off");
    AST_RD: assert property (I_RD && I_ADDR == 8'h1c |=> O_RDATA == $past(O_STATUS))
        else $error("status read wrong");
    AST_CLR: assert property (I_FIFO_CLEAR && !I_FIFO_PUSH
        |=> !O_STATUS[4] && O_STATUS[3:0] == 4'h0 && !O_FIFO_FULL)
        else $error("clear left data");
endmodule
bind fst_fifo_status fst_fifo_status_asserts #(.DEPTH(DEPTH)) u_chk (
    .I_CLK(I_CLK), .I_SRST(I_SRST), .I_CHIP_EN(I_CHIP_EN), .I_ADDR(I_ADDR), .I_WR(I_WR),
    .I_WDATA(I_WDATA), .I_RD(I_RD), .I_FIFO_PUSH(I_FIFO_PUSH), .I_FIFO_CLEAR(I_FIFO_CLEAR),
    .I_TX_EOF(I_TX_EOF), .O_RDATA(O_RDATA), .O_STATUS(O_STATUS), .O_TX_COUNT(O_TX_COUNT),
    .O_TX_PARTIAL(O_TX_PARTIAL), .O_TX_PARTIAL_BITS(O_TX_PARTIAL_BITS),
    .O_FIFO_FULL(O_FIFO_FULL));
`default_nettype wire

// ### fst_host.sv
// Host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module fst_host
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic            wr = 0,
    output logic            rd = 0,
    output logic [7:0]      addr = 0,
    output logic [7:0]      wdata = 0
);
    // One-cycle write; data inverted once released
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk) #1;
        addr = a;
        wdata = v;
        wr = 1;
        @(posedge clk) #1;
        wr = 0;
        wdata = ~v;
    endtask
    // One-cycle read; data taken the cycle after
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk) #1;
        addr = a;
        rd = 1;
        @(posedge clk) #1;
        rd = 0;
        v = rdata;
    endtask
endmodule
`default_nettype wire

// ### fst_fifo_status_test.sv
// Self-checking bench for the FIFO status and length registers
`timescale 1ns/1ps
`default_nettype none
module fst_fifo_status_test;
    logic        clk = 0, srst = 1, en = 1, push = 0, pop = 0, clr = 0;
    logic        rxa = 0, txa = 0, eof = 0, wr, rd, part, full;
    logic [7:0]  addr, wdata, rdata, status, d;
    logic [11:0] cnt;
    logic [2:0]  pbits;
    int          err_count = 0, tests_run = 0;
    fst_host h (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
    fst_fifo_status #(.DEPTH(12)) dut (.I_CLK(clk), .I_SRST(srst), .I_CHIP_EN(en),
        .I_ADDR(addr), .I_WR(wr), .I_WDATA(wdata), .I_RD(rd), .I_FIFO_PUSH(push),
        .I_FIFO_POP(pop), .I_FIFO_CLEAR(clr), .I_RX_ACTIVE(rxa), .I_TX_ACTIVE(txa),
        .I_TX_EOF(eof), .O_RDATA(rdata), .O_STATUS(status), .O_TX_COUNT(cnt),
        .O_TX_PARTIAL(part), .O_TX_PARTIAL_BITS(pbits), .O_FIFO_FULL(full));
    task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        h.rd_reg(a, d);
        chk("rdata", {4'h0, e}, {4'h0, d});
    endtask
    // Holds push or pop for n edges
    task automatic fifo(input int n, input bit p);
        @(posedge clk) #1;
        push = p;
        pop = !p;
        repeat (n) @(posedge clk);
        #1 push = 0;
        pop = 0;
    endtask
    task print_verdict;
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Clock
    initial forever #12.5 clk = ~clk;
    // Watchdog
    initial
    begin
        #20us err_count++;
        print_verdict;
    end
    // Test sequence
    initial
    begin
        repeat (5) @(posedge clk);
        #1 srst = 0;
        repeat (4) @(posedge clk);
        rchk(8'h1d, 8'h00);
        rchk(8'h1c, 8'h00);
        h.wr_reg(8'h1d, 8'hab);
        h.wr_reg(8'h1e, 8'hcd);
        h.wr_reg(8'h1c, 8'hff);
        chk("count", 12'habc, cnt);
        chk("partial", 12'h00e, {8'h00, part, pbits});
        rchk(8'h1e, 8'hcd);
        rchk(8'h1f, 8'h00);
        @(posedge clk) #1 eof = 1;
        @(posedge clk) #1 eof = 0;
        chk("count", 12'h000, cnt);
        chk("partial", 12'h000, {8'h00, part, pbits});
        rchk(8'h1e, 8'h00);
        $display("test length done");
        rxa = 1;
        fifo(9, 1);
        chk("status", 12'h048, {4'h0, status});
        rchk(8'h1c, 8'h48);
        rchk(8'h1c, 8'h48);
        rxa = 0;
        txa = 1;
        fifo(6, 0);
        chk("status", 12'h022, {4'h0, status});
        fifo(9, 1);
        chk("status", 12'h00b, {4'h0, status});
        chk("full", 12'h001, {11'h000, full});
        @(posedge clk) #1 push = 1;
        pop = 1;
        @(posedge clk) #1 push = 0;
        pop = 0;
        chk("status", 12'h00b, {4'h0, status});
        fifo(1, 1);
        chk("status", 12'h01b, {4'h0, status});
        chk("full", 12'h001, {11'h000, full});
        @(posedge clk) #1 clr = 1;
        @(posedge clk) #1 clr = 0;
        chk("status", 12'h020, {4'h0, status});
        chk("full", 12'h000, {11'h000, full});
        $display("test fifo done");
        fifo(2, 1);
        h.wr_reg(8'h1d, 8'h5a);
        chk("count", 12'h5a0, cnt);
        chk("status", 12'h021, {4'h0, status});
        en = 0;
        repeat (5) @(posedge clk);
        h.wr_reg(8'h1d, 8'h77);
        chk("count", 12'h000, cnt);
        chk("status", 12'h020, {4'h0, status});
        $display("test disable done");
        print_verdict;
    end
endmodule
`default_nettype wire
